// ==== verilog/pcm_pkg.sv ====
// Shared constants, opcodes and carrier types for the sequencing and mode register block
package pcm_pkg;

  localparam int unsigned PAGE_W       = 6;
  localparam int unsigned STEP_W       = 6;
  localparam int unsigned PC_W         = PAGE_W + STEP_W;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned STACK_LEVELS = 4;
  localparam int unsigned STEPS_PER_PAGE = 64;

  // Fixed page roles
  localparam logic [PAGE_W-1:0] PAGE_RESET   = 6'h00;
  localparam logic [PAGE_W-1:0] PAGE_SHORT   = 6'h01;
  localparam logic [PAGE_W-1:0] PAGE_INTR    = 6'h02;
  localparam logic [PAGE_W-1:0] PAGE_STANDBY = 6'h03;
  localparam logic [PAGE_W-1:0] PAGE_TABLE   = 6'h04;
  localparam logic [STEP_W-1:0] STEP_ZERO    = 6'h00;

  // Output instruction port addresses
  localparam logic [3:0] ADDR_OUT_ZERO = 4'h0;
  localparam logic [3:0] ADDR_OUT_ONE  = 4'h1;
  localparam logic [3:0] ADDR_OUT_TWO  = 4'h2;
  localparam logic [3:0] ADDR_MELODY   = 4'hD;
  localparam logic [3:0] ADDR_MASK     = 4'hE;
  localparam logic [3:0] ADDR_DISPLAY  = 4'hF;

  // Writable bits of each output latch and mode register; the rest hold zero
  localparam logic [3:0] MASK_OUT     = 4'hF;
  localparam logic [3:0] MASK_MELODY  = 4'h1;
  localparam logic [3:0] MASK_INTR    = 4'h5;
  localparam logic [3:0] MASK_DISPLAY = 4'h7;

  // Field positions
  localparam int unsigned BIT_MELODY_RUN = 0;
  localparam int unsigned BIT_EXT_ALLOW  = 0;
  localparam int unsigned BIT_DIV_ALLOW  = 2;
  localparam int unsigned BIT_LCD_ON     = 0;
  localparam int unsigned BIT_BOOST_ON   = 1;
  localparam int unsigned BIT_SYS_SLOW   = 2;
  localparam int unsigned BIT_PIN_READ   = 0;

  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [1:0] DIV_FAST  = 2'h1;
  localparam logic [1:0] DIV_SLOW  = 2'h3;

  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_STEP      = 4'h1,
    OP_JUMP      = 4'h2,
    OP_CALL      = 4'h3,
    OP_SHORT     = 4'h4,
    OP_TABLE     = 4'h5,
    OP_RETURN    = 4'h6,
    OP_INTR      = 4'h7,
    OP_STANDBY   = 4'h8,
    OP_OUT       = 4'h9,
    OP_IN        = 4'hA,
    OP_TEST_MEL  = 4'hB,
    OP_TEST_EXT  = 4'hC,
    OP_TEST_DIV  = 4'hD,
    OP_CARRY_SET = 4'hE,
    OP_CARRY_CLR = 4'hF
  } core_op_e;

  typedef struct packed {
    core_op_e          op;
    logic [PC_W-1:0]   target;
    logic [3:0]        port;
    logic [NIB_W-1:0]  work_nibble;
  } core_req_s;

  typedef struct packed {
    logic ext_intr_set;
    logic div_intr_set;
    logic melody_stop;
  } hw_event_s;

  typedef struct packed {
    logic carry;
    logic ext_intr_flag;
    logic div_intr_flag;
  } core_flags_s;

endpackage

// ==== verilog/nibble_latch.sv ====
// One 4-bit latch loaded from the work nibble when the output instruction selects it
`timescale 1ns/1ps
`default_nettype none
module nibble_latch
  import pcm_pkg::*;
#(
  parameter logic [3:0] ADDR     = 4'h0,
  parameter logic [3:0] WR_MASK  = 4'hF
)(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic              wr_i,
  input  wire logic [3:0]        port_i,
  input  wire logic [NIB_W-1:0]  data_i,
  output var  logic [NIB_W-1:0]  q_o
);

  logic [NIB_W-1:0] next_q;

  always_comb
  begin
    next_q = q_o;
    if (wr_i && (port_i == ADDR))
    begin
      next_q = data_i & WR_MASK;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      q_o <= NIB_RESET;
    end
    else
    begin
      q_o <= next_q;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/pc_mode_regs.sv ====
// Program counter, call stack, flags, output latches and mode registers of the core
// Functional notes
// - 12-bit counter: 6-bit page, 6-bit step
// - Pages of 64 steps, 32/48/64 pages
// - Table lookup pushes one stack level
// - Fixed entry pages zero to four
// - Carry, external and divider interrupt flags
// - Three output latches loaded from work nibble
// - Mode registers written like output latches
// - Input reads raw pin into bit 0
// - Melody run bit sets/clears melody flop
// - Stop code sets end flag; test clears
// - External interrupt allow bit masks request
// - Divider interrupt allow bit masks request
// - LCD and booster enable bits
// - System clock divide by 2 or 4
// - Reset selects divide-by-2 system clock
`timescale 1ns/1ps
`default_nettype none
module pc_mode_regs
  import pcm_pkg::*;
#(
  parameter int unsigned PAGES = 64
)(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire core_req_s         req_i,
  input  wire hw_event_s         event_i,
  input  wire logic              alu_carry_i,
  input  wire logic              alu_carry_we_i,
  input  wire logic              ext_intr_pin_i,
  output var  logic [PC_W-1:0]   pc_o,
  output var  logic [2:0]        stack_used_o,
  output var  core_flags_s       flags_o,
  output var  logic [NIB_W-1:0]  read_nibble_o,
  output var  logic              test_result_o,
  output var  logic [NIB_W-1:0]  out_port_zero_o,
  output var  logic [NIB_W-1:0]  out_port_one_o,
  output var  logic [NIB_W-1:0]  out_port_two_o,
  output var  logic [NIB_W-1:0]  melody_control_o,
  output var  logic [NIB_W-1:0]  interrupt_enable_mask_o,
  output var  logic [NIB_W-1:0]  display_clock_control_o,
  output var  logic              melody_flop_o,
  output var  logic              melody_start_o,
  output var  logic              intr_request_o,
  output var  logic              sys_tick_o
);

  if (!(PAGES == 32 || PAGES == 48 || PAGES == 64))
  begin
    $error("PAGES must be 32, 48 or 64");
  end

  typedef struct packed {
    logic [PAGE_W-1:0]                   page_field;
    logic [STEP_W-1:0]                   step_counter;
    logic [STACK_LEVELS-1:0][PC_W-1:0]   call_stack;
    logic [2:0]                          used;
    core_flags_s                         flags;
    logic                                melody_flop;
    logic                                melody_start;
    logic                                melody_end_flag;
    logic [NIB_W-1:0]                    read_nibble;
    logic                                test_result;
    logic                                intr_request;
    logic [1:0]                          div_count;
    logic                                sys_tick;
  } core_state_s;

  core_state_s st;
  core_state_s next_st;

  logic [NIB_W-1:0] melody_bits;
  logic [NIB_W-1:0] mask_bits;
  logic [NIB_W-1:0] next_mask;
  logic [NIB_W-1:0] display_bits;
  logic             out_wr;
  logic [PC_W-1:0]  ret_addr;
  logic             push;
  logic             page_ok;

  assign out_wr   = (req_i.op == OP_OUT);
  assign ret_addr = {st.page_field, st.step_counter + 6'h01};
  assign page_ok  = (32'(req_i.target[PC_W-1:STEP_W]) < PAGES);
  // Request follows the mask being written in the same cycle
  assign next_mask = (out_wr && (req_i.port == ADDR_MASK)) ?
                     (req_i.work_nibble & MASK_INTR) : mask_bits;

  // Output latches and mode registers share one write path
  nibble_latch #(.ADDR(ADDR_OUT_ZERO), .WR_MASK(MASK_OUT)) u_out_zero (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (out_wr),
    .port_i    (req_i.port),
    .data_i    (req_i.work_nibble),
    .q_o       (out_port_zero_o)
  );
  nibble_latch #(.ADDR(ADDR_OUT_ONE), .WR_MASK(MASK_OUT)) u_out_one (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (out_wr),
    .port_i    (req_i.port),
    .data_i    (req_i.work_nibble),
    .q_o       (out_port_one_o)
  );
  nibble_latch #(.ADDR(ADDR_OUT_TWO), .WR_MASK(MASK_OUT)) u_out_two (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (out_wr),
    .port_i    (req_i.port),
    .data_i    (req_i.work_nibble),
    .q_o       (out_port_two_o)
  );
  nibble_latch #(.ADDR(ADDR_MELODY), .WR_MASK(MASK_MELODY)) u_melody (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (out_wr),
    .port_i    (req_i.port),
    .data_i    (req_i.work_nibble),
    .q_o       (melody_bits)
  );
  nibble_latch #(.ADDR(ADDR_MASK), .WR_MASK(MASK_INTR)) u_mask (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (out_wr),
    .port_i    (req_i.port),
    .data_i    (req_i.work_nibble),
    .q_o       (mask_bits)
  );
  nibble_latch #(.ADDR(ADDR_DISPLAY), .WR_MASK(MASK_DISPLAY)) u_display (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (out_wr),
    .port_i    (req_i.port),
    .data_i    (req_i.work_nibble),
    .q_o       (display_bits)
  );

  // Calls, short calls, table lookups, interrupt entries and standby entries push the return address
  assign push = (req_i.op == OP_CALL) || (req_i.op == OP_SHORT) ||
                (req_i.op == OP_TABLE) || (req_i.op == OP_INTR) ||
                (req_i.op == OP_STANDBY);

  always_comb
  begin
    next_st              = st;
    next_st.melody_start = 1'b0;
    next_st.test_result  = 1'b0;
    if (push)
    begin
      next_st.call_stack = {st.call_stack[STACK_LEVELS-2:0], ret_addr};
      if (st.used < 3'(STACK_LEVELS))
      begin
        next_st.used = st.used + 3'h1;
      end
    end
    case (req_i.op)
      OP_STEP:
      begin
        next_st.step_counter = st.step_counter + 6'h01;
      end
      OP_JUMP, OP_CALL:
      begin
        if (page_ok)
        begin
          next_st.page_field   = req_i.target[PC_W-1:STEP_W];
          next_st.step_counter = req_i.target[STEP_W-1:0];
        end
        else
        begin
          next_st.step_counter = st.step_counter + 6'h01;
        end
      end
      OP_SHORT:
      begin
        next_st.page_field   = PAGE_SHORT;
        next_st.step_counter = req_i.target[STEP_W-1:0];
      end
      OP_TABLE:
      begin
        next_st.page_field   = PAGE_TABLE;
        next_st.step_counter = req_i.target[STEP_W-1:0];
      end
      OP_INTR:
      begin
        next_st.page_field   = PAGE_INTR;
        next_st.step_counter = STEP_ZERO;
      end
      OP_STANDBY:
      begin
        next_st.page_field   = PAGE_STANDBY;
        next_st.step_counter = STEP_ZERO;
      end
      OP_RETURN:
      begin
        {next_st.page_field, next_st.step_counter} = st.call_stack[0];
        next_st.call_stack = {st.call_stack[0], st.call_stack[STACK_LEVELS-1:1]};
        if (st.used != 3'h0)
        begin
          next_st.used = st.used - 3'h1;
        end
      end
      OP_OUT:
      begin
        next_st.step_counter = st.step_counter + 6'h01;
        if (req_i.port == ADDR_MELODY)
        begin
          next_st.melody_flop  = req_i.work_nibble[BIT_MELODY_RUN];
          next_st.melody_start = req_i.work_nibble[BIT_MELODY_RUN];
        end
      end
      OP_IN:
      begin
        next_st.step_counter = st.step_counter + 6'h01;
        next_st.read_nibble  = NIB_RESET;
        next_st.read_nibble[BIT_PIN_READ] = ext_intr_pin_i;
      end
      OP_TEST_MEL:
      begin
        next_st.step_counter    = st.step_counter + 6'h01;
        next_st.test_result     = st.melody_end_flag;
        next_st.melody_end_flag = 1'b0;
      end
      OP_TEST_EXT:
      begin
        next_st.step_counter        = st.step_counter + 6'h01;
        next_st.test_result         = st.flags.ext_intr_flag;
        next_st.flags.ext_intr_flag = 1'b0;
      end
      OP_TEST_DIV:
      begin
        next_st.step_counter        = st.step_counter + 6'h01;
        next_st.test_result         = st.flags.div_intr_flag;
        next_st.flags.div_intr_flag = 1'b0;
      end
      OP_CARRY_SET:
      begin
        next_st.step_counter = st.step_counter + 6'h01;
        next_st.flags.carry  = 1'b1;
      end
      OP_CARRY_CLR:
      begin
        next_st.step_counter = st.step_counter + 6'h01;
        next_st.flags.carry  = 1'b0;
      end
      default:
      begin
        next_st.step_counter = st.step_counter;
      end
    endcase
    if (alu_carry_we_i)
    begin
      next_st.flags.carry = alu_carry_i;
    end
    // Hardware events win over a clear in the same cycle
    if (event_i.ext_intr_set)
    begin
      next_st.flags.ext_intr_flag = 1'b1;
    end
    if (event_i.div_intr_set)
    begin
      next_st.flags.div_intr_flag = 1'b1;
    end
    if (event_i.melody_stop)
    begin
      next_st.melody_end_flag = 1'b1;
    end
    next_st.intr_request =
      (next_st.flags.ext_intr_flag & next_mask[BIT_EXT_ALLOW]) |
      (next_st.flags.div_intr_flag & next_mask[BIT_DIV_ALLOW]);
    // System clock tick from the main oscillation
    if (st.div_count == 2'h0)
    begin
      next_st.div_count = display_bits[BIT_SYS_SLOW] ? DIV_SLOW : DIV_FAST;
      next_st.sys_tick  = 1'b1;
    end
    else
    begin
      next_st.div_count = st.div_count - 2'h1;
      next_st.sys_tick  = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st            <= '0;
      st.page_field <= PAGE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pc_o                    = {st.page_field, st.step_counter};
  assign stack_used_o            = st.used;
  assign flags_o                 = st.flags;
  assign read_nibble_o           = st.read_nibble;
  assign test_result_o           = st.test_result;
  assign melody_control_o        = {melody_bits[3:2], st.melody_end_flag,
                                    melody_bits[BIT_MELODY_RUN]};
  assign interrupt_enable_mask_o = mask_bits;
  assign display_clock_control_o = display_bits;
  assign melody_flop_o           = st.melody_flop;
  assign melody_start_o          = st.melody_start;
  assign intr_request_o          = st.intr_request;
  assign sys_tick_o              = st.sys_tick;

  property p_table_push;
    @(posedge clock_i) disable iff (sys_rst_i)
    (req_i.op == OP_TABLE && stack_used_o < 3'h4)
      |=> (stack_used_o == $past(stack_used_o) + 3'h1) && (pc_o[11:6] == PAGE_TABLE);
  endproperty
  a_table_push: assert property (p_table_push) else $error("table lookup push wrong");

  property p_step_adv;
    @(posedge clock_i) disable iff (sys_rst_i)
    (req_i.op == OP_STEP) |=> (pc_o[5:0] == $past(pc_o[5:0]) + 6'h01)
                              && (pc_o[11:6] == $past(pc_o[11:6]));
  endproperty
  a_step_adv: assert property (p_step_adv) else $error("step counter wrong");

  property p_intr_page;
    @(posedge clock_i) disable iff (sys_rst_i)
    (req_i.op == OP_INTR) |=> (pc_o == 12'h080);
  endproperty
  a_intr_page: assert property (p_intr_page) else $error("interrupt entry wrong");

  property p_pin_read;
    @(posedge clock_i) disable iff (sys_rst_i)
    (req_i.op == OP_IN) |=> (read_nibble_o == {3'h0, $past(ext_intr_pin_i)});
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

  property p_melody_run;
    @(posedge clock_i) disable iff (sys_rst_i)
    (out_wr && req_i.port == ADDR_MELODY)
      |=> (melody_flop_o == $past(req_i.work_nibble[0])) && (melody_control_o[3:2] == 2'h0);
  endproperty
  a_melody_run: assert property (p_melody_run) else $error("melody flop wrong");

  property p_end_set_wins;
    @(posedge clock_i) disable iff (sys_rst_i)
    event_i.melody_stop |=> melody_control_o[1];
  endproperty
  a_end_set_wins: assert property (p_end_set_wins) else $error("end flag lost");

  property p_ext_mask;
    @(posedge clock_i) disable iff (sys_rst_i)
    intr_request_o |-> (flags_o.ext_intr_flag && interrupt_enable_mask_o[0]) ||
                       (flags_o.div_intr_flag && interrupt_enable_mask_o[2]);
  endproperty
  a_ext_mask: assert property (p_ext_mask) else $error("masked interrupt raised");

  property p_div_accept;
    @(posedge clock_i) disable iff (sys_rst_i)
    (event_i.div_intr_set && interrupt_enable_mask_o[2] && !out_wr) |=> intr_request_o;
  endproperty
  a_div_accept: assert property (p_div_accept) else $error("divider request lost");

  property p_unused_zero;
    @(posedge clock_i) disable iff (sys_rst_i)
    (interrupt_enable_mask_o[3] == 1'b0) && (interrupt_enable_mask_o[1] == 1'b0)
      && (display_clock_control_o[3] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_fast_tick;
    @(posedge clock_i) disable iff (sys_rst_i)
    (sys_tick_o && !display_clock_control_o[2] && !$past(display_clock_control_o[2]))
      |=> !sys_tick_o ##1 (sys_tick_o || display_clock_control_o[2]);
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("divide by 2 wrong");

  c_table_return: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    req_i.op == OP_TABLE ##[1:8] req_i.op == OP_RETURN);
  c_melody_start: cover property (@(posedge clock_i) disable iff (sys_rst_i) melody_start_o);
  c_intr_req: cover property (@(posedge clock_i) disable iff (sys_rst_i) intr_request_o);
  c_slow_clock: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    display_clock_control_o[2] && sys_tick_o);

endmodule
`default_nettype wire

// ==== tb/test_pc_and_mode_registers.sv ====
// Self-checking bench for the sequencing and mode register block
`timescale 1ns/1ps
`default_nettype none
module test_pc_and_mode_registers
  import pcm_pkg::*;
;
  localparam int unsigned PAGES = 48;

  logic                 clock_i        = 1'b0;
  logic                 sys_rst_i      = 1'b1;
  core_req_s            req_i          = '0;
  hw_event_s            event_i        = '0;
  logic                 alu_carry_i    = 1'b0;
  logic                 alu_carry_we_i = 1'b0;
  logic                 ext_intr_pin_i = 1'b0;
  logic [PC_W-1:0]      pc_o;
  logic [2:0]           stack_used_o;
  core_flags_s          flags_o;
  logic [NIB_W-1:0]     read_nibble_o;
  logic                 test_result_o;
  logic [NIB_W-1:0]     out_port_zero_o;
  logic [NIB_W-1:0]     out_port_one_o;
  logic [NIB_W-1:0]     out_port_two_o;
  logic [NIB_W-1:0]     melody_control_o;
  logic [NIB_W-1:0]     interrupt_enable_mask_o;
  logic [NIB_W-1:0]     display_clock_control_o;
  logic                 melody_flop_o;
  logic                 melody_start_o;
  logic                 intr_request_o;
  logic                 sys_tick_o;

  // Reference model state
  logic [11:0]          m_pc;
  bit                   pc_ok;
  logic [12:0]          stk[$];
  logic                 m_c, m_e, m_d, m_end, m_run, m_tres, m_start, m_irq;
  logic [3:0]           m_out0, m_out1, m_out2, m_mask, m_disp, m_read;
  logic                 slow_seen   = 1'b0;
  int                   seed        = 48006;
  int                   mismatches  = 0;
  int                   check_count = 0;
  int                   gap         = 0;
  int                   skip        = 1;
  logic [31:0]          rv, rv2;

  pc_mode_regs #(.PAGES(PAGES)) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .event_i(event_i),
    .alu_carry_i(alu_carry_i), .alu_carry_we_i(alu_carry_we_i),
    .ext_intr_pin_i(ext_intr_pin_i), .pc_o(pc_o), .stack_used_o(stack_used_o),
    .flags_o(flags_o), .read_nibble_o(read_nibble_o), .test_result_o(test_result_o),
    .out_port_zero_o(out_port_zero_o), .out_port_one_o(out_port_one_o),
    .out_port_two_o(out_port_two_o), .melody_control_o(melody_control_o),
    .interrupt_enable_mask_o(interrupt_enable_mask_o),
    .display_clock_control_o(display_clock_control_o), .melody_flop_o(melody_flop_o),
    .melody_start_o(melody_start_o), .intr_request_o(intr_request_o),
    .sys_tick_o(sys_tick_o)
  );

  always #50 clock_i = ~clock_i;

  function void push(logic [12:0] v);
    stk.push_back(v);
    if (stk.size() > STACK_LEVELS)
      void'(stk.pop_front());
  endfunction

  task automatic check_val(string name, logic [11:0] exp, logic [11:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic drive(core_op_e op, logic [11:0] tgt, logic [3:0] prt, logic [3:0] nib,
                       hw_event_s ev = '0);
    @(posedge clock_i);
    req_i   <= '{op: op, target: tgt, port: prt, work_nibble: nib};
    event_i <= ev;
  endtask

  // Model advances on the same edge as the design
  always @(posedge clock_i)
  begin : model
    logic [11:0] nxt;
    logic [12:0] e;
    core_op_e    op;
    op = req_i.op;
    nxt = {m_pc[11:6], m_pc[5:0] + 6'h01};
    e = {pc_ok, nxt};
    if (sys_rst_i)
    begin
      m_pc = '0;
      pc_ok = 1'b1;
      stk.delete();
      {m_c, m_e, m_d, m_end, m_run, m_tres, m_start, m_irq} = '0;
      {m_out0, m_out1, m_out2, m_mask, m_disp, m_read} = '0;
    end
    else
    begin
      case (op)
        OP_STEP: m_pc = nxt;
        OP_JUMP, OP_CALL:
        begin
          if (op == OP_CALL)
            push(e);
          pc_ok = (req_i.target[11:6] < PAGES) ? 1'b1 : pc_ok;
          m_pc = (req_i.target[11:6] < PAGES) ? req_i.target : nxt;
        end
        OP_SHORT, OP_TABLE, OP_INTR, OP_STANDBY:
        begin
          push(e);
          pc_ok = 1'b1;
          m_pc = (op == OP_SHORT) ? {PAGE_SHORT, req_i.target[5:0]} :
                 (op == OP_TABLE) ? {PAGE_TABLE, req_i.target[5:0]} :
                 (op == OP_INTR)  ? {PAGE_INTR, STEP_ZERO} : {PAGE_STANDBY, STEP_ZERO};
        end
        OP_RETURN:
        begin
          pc_ok = 1'b0;
          if (stk.size() > 0)
          begin
            e = stk.pop_back();
            m_pc = e[11:0];
            pc_ok = e[12];
          end
        end
        OP_NONE: ;
        default: m_pc = nxt;
      endcase
      if (op == OP_OUT)
      begin
        case (req_i.port)
          ADDR_OUT_ZERO: m_out0 = req_i.work_nibble;
          ADDR_OUT_ONE:  m_out1 = req_i.work_nibble;
          ADDR_OUT_TWO:  m_out2 = req_i.work_nibble;
          ADDR_MELODY:   m_run = req_i.work_nibble[0];
          ADDR_MASK:     m_mask = req_i.work_nibble & 4'h5;
          ADDR_DISPLAY:  m_disp = req_i.work_nibble & 4'h7;
          default: ;
        endcase
      end
      m_start = (op == OP_OUT) && (req_i.port == ADDR_MELODY) && req_i.work_nibble[0];
      if (op == OP_IN)
        m_read = {3'b000, ext_intr_pin_i};
      m_c = (op == OP_CARRY_SET) ? 1'b1 : (op == OP_CARRY_CLR) ? 1'b0 : m_c;
      m_c = alu_carry_we_i ? alu_carry_i : m_c;
      m_tres = (op == OP_TEST_MEL) ? m_end : (op == OP_TEST_EXT) ? m_e :
               (op == OP_TEST_DIV) ? m_d : 1'b0;
      m_end = (m_end && op != OP_TEST_MEL) || event_i.melody_stop;
      m_e = (m_e && op != OP_TEST_EXT) || event_i.ext_intr_set;
      m_d = (m_d && op != OP_TEST_DIV) || event_i.div_intr_set;
      m_irq = (m_e & m_mask[0]) | (m_d & m_mask[2]);
    end
  end

  // Compare settled results against the model; pc only while pc_ok is set
  always @(negedge clock_i)
  begin
    if (pc_ok)
      check_val("pc", m_pc, pc_o);
    check_val("stack_used", 12'(stk.size()), 12'(stack_used_o));
    check_val("flags", {9'h000, m_c, m_e, m_d}, 12'(flags_o));
    check_val("read_nibble", 12'(m_read), 12'(read_nibble_o));
    check_val("out_ports", {m_out0, m_out1, m_out2},
              {out_port_zero_o, out_port_one_o, out_port_two_o});
    check_val("mode_regs", {2'b00, m_end, m_run, m_mask, m_disp}, {melody_control_o,
              interrupt_enable_mask_o, display_clock_control_o});
    check_val("melody_irq", {8'h00, m_run, m_start, m_tres, m_irq}, {8'h00, melody_flop_o,
              melody_start_o, test_result_o, intr_request_o});
    if (sys_rst_i)
    begin
      gap = 0;
      skip = 1;
      slow_seen = 1'b0;
    end
    else
    begin
      // A divide change lets the tick in flight finish at the old rate
      if (m_disp[2] !== slow_seen)
        skip = 2;
      slow_seen = m_disp[2];
      gap++;
      if (sys_tick_o === 1'b1)
      begin
        if (skip == 0)
          check_val("tick_gap", m_disp[2] ? 12'h004 : 12'h002, 12'(gap));
        else
          skip--;
        gap = 0;
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    wrap_up();
  end

  initial
  begin : main
    core_op_e calls[5];
    calls = '{OP_SHORT, OP_INTR, OP_STANDBY, OP_TABLE, OP_CALL};
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    check_val("first_tick", 12'h001, 12'(sys_tick_o));
    drive(OP_JUMP, {6'(PAGES), 6'h00}, 4'h0, 4'h0);
    drive(OP_JUMP, {6'(PAGES - 1), 6'h3F}, 4'h0, 4'h0);
    drive(OP_STEP, 12'h000, 4'h0, 4'h0);
    drive(OP_TABLE, 12'h005, 4'h0, 4'h0);
    drive(OP_RETURN, 12'h000, 4'h0, 4'h0);
    foreach (calls[i])
      drive(calls[i], 12'h147, 4'h0, 4'h0);
    repeat (5) drive(OP_RETURN, 12'h000, 4'h0, 4'h0);
    drive(OP_JUMP, 12'h000, 4'h0, 4'h0);
    for (int p = 0; p < 16; p++)
      drive(OP_OUT, 12'h000, 4'(p), 4'hF);
    repeat (12) drive(OP_STEP, 12'h000, 4'h0, 4'h0);
    drive(OP_TEST_EXT, 12'h000, 4'h0, 4'h0, '{1'b1, 1'b0, 1'b0});
    drive(OP_TEST_EXT, 12'h000, 4'h0, 4'h0);
    drive(OP_TEST_MEL, 12'h000, 4'h0, 4'h0, '{1'b0, 1'b0, 1'b1});
    drive(OP_TEST_MEL, 12'h000, 4'h0, 4'h0);
    drive(OP_TEST_DIV, 12'h000, 4'h0, 4'h0, '{1'b0, 1'b1, 1'b0});
    drive(OP_TEST_DIV, 12'h000, 4'h0, 4'h0);
    drive(OP_OUT, 12'h000, ADDR_MELODY, 4'h0);
    drive(OP_OUT, 12'h000, ADDR_MASK, 4'h0, '{1'b1, 1'b1, 1'b0});
    drive(OP_OUT, 12'h000, ADDR_DISPLAY, 4'h0);
    ext_intr_pin_i <= 1'b1;
    drive(OP_IN, 12'h000, 4'h0, 4'h0);
    repeat (8) drive(OP_STEP, 12'h000, 4'h0, 4'h0);
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clock_i);
      rv = $random(seed);
      rv2 = $random(seed);
      req_i <= '{op: core_op_e'(rv[3:0]), target: rv[15:4], port: rv[19:16],
                 work_nibble: rv[23:20]};
      event_i <= hw_event_s'({&rv[26:24], &rv[29:27], &rv2[7:5]});
      alu_carry_i <= rv2[0];
      alu_carry_we_i <= &rv2[3:1];
      ext_intr_pin_i <= rv2[4];
      if (i == 1500)
        sys_rst_i <= 1'b1;
      if (i == 1503)
        sys_rst_i <= 1'b0;
    end
    drive(OP_STEP, 12'h000, 4'h0, 4'h0);
    repeat (4) @(posedge clock_i);
    wrap_up();
  end
endmodule
`default_nettype wire
